// file: design/fsk_detect_pkg.sv
// Shared constants, field layout and decode helpers for the FSK detection block
package fsk_detect_pkg;

  // Register byte offsets
  localparam logic [3:0] ADDR_DEMOD_SETUP = 4'h0;
  localparam logic [3:0] ADDR_DETECT_SETUP = 4'h4;
  localparam logic [3:0] ADDR_SYMBOL_DIV = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;

  // Demodulator setup fields
  localparam int SEL_LSB = 4;
  localparam int SEL_MSB = 6;
  localparam int COEF_ODD_BIT = 7;
  localparam int COEF_HALF_LSB = 8;
  localparam int COEF_HALF_MSB = 9;
  localparam int CORR_BW_LSB = 10;
  localparam int CORR_BW_MSB = 19;
  localparam int POST_BW_LSB = 20;
  localparam int POST_BW_MSB = 29;

  // Detector setup fields
  localparam int SLICE_LSB = 4;
  localparam int SLICE_MSB = 10;
  localparam int TRELLIS_BIT = 11;
  localparam int PHASE_CORR_BIT = 12;
  localparam int PATH_LSB = 13;
  localparam int PATH_MSB = 14;
  localparam int RECOV_LSB = 15;
  localparam int RECOV_MSB = 21;
  localparam int QUAL_LSB = 22;
  localparam int QUAL_MSB = 25;

  // Reset values
  localparam logic [31:0] DEMOD_SETUP_RST = 32'h0000_0000;
  localparam logic [31:0] DETECT_SETUP_RST = 32'h03C0_1000;
  localparam logic [15:0] SYMBOL_DIV_RST = 16'h0000;

  // Demodulator select codes
  localparam logic [2:0] SEL_LINEAR = 3'h0;
  localparam logic [2:0] SEL_CORR_2FSK = 3'h1;
  localparam logic [2:0] SEL_CORR_3FSK = 3'h2;
  localparam logic [2:0] SEL_CORR_4FSK = 3'h3;

  // Timing and scaling
  localparam logic [4:0] OVERSAMPLE_LAST = 5'h1F;
  localparam logic [4:0] PHASE_REALIGN = 5'h10;
  localparam int THR_SHIFT = 4;
  localparam logic [9:0] ENV_BW = 10'h008;

  typedef enum {MODE_LINEAR, MODE_2FSK, MODE_3FSK, MODE_4FSK, MODE_OFF} mode_t;

  // Map the select field onto a demodulation mode
  function automatic mode_t decode_mode(input logic [2:0] sel);
    if (sel == SEL_LINEAR) decode_mode = MODE_LINEAR;
    else if (sel == SEL_CORR_2FSK) decode_mode = MODE_2FSK;
    else if (sel == SEL_CORR_3FSK) decode_mode = MODE_3FSK;
    else if (sel == SEL_CORR_4FSK) decode_mode = MODE_4FSK;
    else decode_mode = MODE_OFF;
  endfunction : decode_mode

  // Trellis path memory depth in bits
  function automatic logic [5:0] path_depth(input logic [1:0] code);
    case (code)
      2'h0: path_depth = 6'h04;
      2'h1: path_depth = 6'h06;
      2'h2: path_depth = 6'h08;
      default: path_depth = 6'h20;
    endcase
  endfunction : path_depth

endpackage : fsk_detect_pkg

// file: design/multilevel_slicer.sv
// Multilevel threshold slicer for two, three and four level symbols
`timescale 1ns/100ps
module multilevel_slicer (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Sample and controls
  input wire logic i_strobe,
  input wire logic signed [15:0] i_sample,
  input wire logic signed [15:0] i_centre,
  input wire logic [6:0] i_slice_level,
  input wire logic [1:0] i_levels,
  // Decision
  output logic [1:0] o_symbol
);

  logic signed [15:0] thr;
  logic signed [16:0] rel;

  // Offset threshold is placed symmetrically about the centre
  assign thr = $signed(16'({i_slice_level, {fsk_detect_pkg::THR_SHIFT{1'b0}}}));
  assign rel = 17'(i_sample) - 17'(i_centre);

  // Decide on each strobe; levels 0 = two, 1 = three, 2 = four
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_symbol <= 2'h0;
    end else if (i_strobe) begin
      case (i_levels)
        2'h1: begin
          if (rel > 17'(thr)) o_symbol <= 2'h1;
          else if (rel < -17'(thr)) o_symbol <= 2'h3;
          else o_symbol <= 2'h0;
        end
        2'h2: begin
          if (rel > 17'(thr)) o_symbol <= 2'h3;
          else if (rel >= 17'sh0) o_symbol <= 2'h2;
          else if (rel >= -17'(thr)) o_symbol <= 2'h1;
          else o_symbol <= 2'h0;
        end
        default: o_symbol <= {1'b0, ~rel[16]};
      endcase
    end
  end

endmodule : multilevel_slicer

// file: design/symbol_delay_line.sv
// Programmable symbol delay that models the trellis decision latency
`timescale 1ns/100ps
module symbol_delay_line (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Stream
  input wire logic i_push,
  input wire logic [1:0] i_symbol,
  input wire logic [6:0] i_length,
  // Delayed symbol, valid in the push cycle
  output logic [1:0] o_symbol
);

  logic [1:0] store [64];
  logic [5:0] wr_ptr;

  // Oldest entry sits length pushes back
  assign o_symbol = store[wr_ptr - i_length[5:0]];

  // Write pointer
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr <= 6'h00;
    end else if (i_push) begin
      wr_ptr <= wr_ptr + 6'h01;
    end
  end

  // Symbol storage
  always_ff @(posedge i_mclk) begin
    if (i_push) begin
      store[wr_ptr] <= i_symbol;
    end
  end

endmodule : symbol_delay_line

// file: design/fsk_demod_detect_config.sv
// FSK demodulation path: setup registers, post filter, slicing, trellis delay and clock recovery
// Behaviour
// - Select codes 001, 010, 011 choose correlator 2FSK, 3FSK, 4FSK.
// - Select code 000 chooses linear discriminator, usable for 2FSK only.
// - Correlator bandwidth is the ten-bit field at bits 10 to 19.
// - 2FSK/3FSK coefficient bits follow K parity and half parity.
// - 4FSK coefficient: odd bit from K parity, half bits forced 00.
// - Post filter bandwidth from bits 20 to 29, second order low pass.
// - Detector bit 11 high enables 3FSK trellis detection.
// - Detector bit 11 low uses two-threshold 3FSK slicing.
// - Path memory 4, 6, 8 or 32 bits from bits 13 to 14.
// - Seven-bit slice level at bits 4 to 10 drives 3FSK detection.
// - Detector bit 12 high enables phase correction in 3FSK recovery.
// - Recovery decision threshold from bits 15 to 21.
// - Bits 22 to 25 set the 3FSK preamble qualifying time.
// - Trellis detection adds twice the path memory depth of latency.
// - Slice levels sit symmetrically about zero, or about the slow average in linear mode; 4FSK adds a zero level.
// - Recovery oversampling runs at 32 times the symbol rate.
`timescale 1ns/100ps
module fsk_demod_detect_config (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Discriminator samples, same clock domain
  input wire logic i_sample_valid,
  input wire logic signed [15:0] i_corr_sample,
  input wire logic signed [15:0] i_linear_sample,
  // Correlator configuration
  output logic o_corr_enable,
  output logic [9:0] o_corr_bw,
  output logic o_corr_odd,
  output logic [1:0] o_corr_half,
  // Recovered data
  output logic [1:0] o_rx_symbol,
  output logic o_rx_valid,
  output logic o_preamble_found
);

  logic [31:0] demod_setup;
  logic [31:0] detect_setup;
  logic [15:0] symbol_div;
  fsk_detect_pkg::mode_t mode;
  logic signed [15:0] filt_a;
  logic signed [15:0] filt_b;
  logic signed [15:0] envelope;
  logic signed [15:0] src_sample;
  logic signed [15:0] centre;
  logic signed [15:0] recov_thr;
  logic [1:0] levels;
  logic [1:0] slice_symbol;
  logic [1:0] delayed_symbol;
  logic [1:0] prev_symbol;
  logic [6:0] delay_length;
  logic trellis_on;
  logic [15:0] div_cnt;
  logic ovs_en;
  logic [4:0] phase;
  logic symbol_strobe;
  logic strobe_d;
  logic polarity;
  logic next_polarity;
  logic [3:0] qual_cnt;
  // Setup fields used by several parts of the path
  logic [9:0] post_bw;
  logic [6:0] slice_level;
  logic [6:0] recov_level;
  logic [1:0] path_code;
  logic [3:0] qual_time;

  // One filter step: y + (x - y) * bw / 2048
  function automatic logic signed [15:0] lp_step(input logic signed [15:0] y,
                                                  input logic signed [15:0] x,
                                                  input logic [9:0] bw);
    logic signed [16:0] diff;
    logic signed [27:0] prod;
    diff = 17'(x) - 17'(y);
    // The product keeps eleven fraction bits until the shift
    prod = 28'(diff) * $signed({1'b0, bw});
    lp_step = 16'(18'(y) + 18'(prod >>> 11));
  endfunction : lp_step

  // Demodulator setup register
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      demod_setup <= fsk_detect_pkg::DEMOD_SETUP_RST;
    end else if (i_wr && (i_addr == fsk_detect_pkg::ADDR_DEMOD_SETUP)) begin
      demod_setup <= i_wdata;
    end
  end

  // Detector setup register
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      detect_setup <= fsk_detect_pkg::DETECT_SETUP_RST;
    end else if (i_wr && (i_addr == fsk_detect_pkg::ADDR_DETECT_SETUP)) begin
      detect_setup <= i_wdata;
    end
  end

  // Symbol divider register; the upper half of the word is not stored
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      symbol_div <= fsk_detect_pkg::SYMBOL_DIV_RST;
    end else if (i_wr && (i_addr == fsk_detect_pkg::ADDR_SYMBOL_DIV)) begin
      symbol_div <= i_wdata[15:0];
    end
  end

  // Register reads, answered in the next cycle; unmapped reads return zero
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      if (i_addr == fsk_detect_pkg::ADDR_DEMOD_SETUP) begin
        o_rdata <= demod_setup;
      end else if (i_addr == fsk_detect_pkg::ADDR_DETECT_SETUP) begin
        o_rdata <= detect_setup;
      end else if (i_addr == fsk_detect_pkg::ADDR_SYMBOL_DIV) begin
        o_rdata <= {16'h0000, symbol_div};
      end else if (i_addr == fsk_detect_pkg::ADDR_STATUS) begin
        // Status packs symbol, count, trellis flag and preamble flag
        o_rdata <= {24'h00_0000, o_preamble_found, trellis_on, qual_cnt, o_rx_symbol};
      end else begin
        o_rdata <= 32'h0000_0000;
      end
    end
  end

  assign mode = fsk_detect_pkg::decode_mode(
      demod_setup[fsk_detect_pkg::SEL_MSB:fsk_detect_pkg::SEL_LSB]);

  // Field extraction from the two setup words
  assign post_bw = demod_setup[fsk_detect_pkg::POST_BW_MSB:fsk_detect_pkg::POST_BW_LSB];
  assign slice_level = detect_setup[fsk_detect_pkg::SLICE_MSB:fsk_detect_pkg::SLICE_LSB];
  assign recov_level = detect_setup[fsk_detect_pkg::RECOV_MSB:fsk_detect_pkg::RECOV_LSB];
  assign path_code = detect_setup[fsk_detect_pkg::PATH_MSB:fsk_detect_pkg::PATH_LSB];
  assign qual_time = detect_setup[fsk_detect_pkg::QUAL_MSB:fsk_detect_pkg::QUAL_LSB];

  // Correlator controls follow the setup register
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_corr_enable <= 1'b0;
      o_corr_bw <= 10'h000;
      o_corr_odd <= 1'b0;
      o_corr_half <= 2'h0;
    end else begin
      o_corr_enable <= (mode == fsk_detect_pkg::MODE_2FSK) ||
                       (mode == fsk_detect_pkg::MODE_3FSK) ||
                       (mode == fsk_detect_pkg::MODE_4FSK);
      o_corr_bw <= demod_setup[fsk_detect_pkg::CORR_BW_MSB:fsk_detect_pkg::CORR_BW_LSB];
      o_corr_odd <= demod_setup[fsk_detect_pkg::COEF_ODD_BIT];
      if (mode == fsk_detect_pkg::MODE_4FSK) begin
        o_corr_half <= 2'h0;
      end else begin
        o_corr_half <= demod_setup[fsk_detect_pkg::COEF_HALF_MSB:fsk_detect_pkg::COEF_HALF_LSB];
      end
    end
  end

  assign src_sample = (mode == fsk_detect_pkg::MODE_LINEAR) ? i_linear_sample : i_corr_sample;

  // second order post filter as two cascaded first order sections
  // Both sections share one bandwidth, so the response does not overshoot
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      filt_a <= 16'sh0000;
      filt_b <= 16'sh0000;
    end else if (i_sample_valid) begin
      filt_a <= lp_step(filt_a, src_sample,
                        post_bw);
      filt_b <= lp_step(filt_b, filt_a,
                        post_bw);
    end
  end

  // Slow average that tracks the frequency offset for the linear slicer
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      envelope <= 16'sh0000;
    end else if (i_sample_valid) begin
      envelope <= lp_step(envelope, filt_b, fsk_detect_pkg::ENV_BW);
    end
  end

  // centre at zero except linear
  // Linear mode slices against the slow average to cancel a frequency offset
  assign centre = (mode == fsk_detect_pkg::MODE_LINEAR) ? envelope : 16'sh0000;
  assign levels = (mode == fsk_detect_pkg::MODE_3FSK) ? 2'h1 :
                  (mode == fsk_detect_pkg::MODE_4FSK) ? 2'h2 : 2'h0;

  multilevel_slicer u_slicer (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_strobe(symbol_strobe),
    .i_sample(filt_b),
    .i_centre(centre),
    .i_slice_level(slice_level),
    .i_levels(levels),
    .o_symbol(slice_symbol)
  );

  assign trellis_on = detect_setup[fsk_detect_pkg::TRELLIS_BIT] &&
                      (mode == fsk_detect_pkg::MODE_3FSK);
  // twice the path depth
  // The delay line runs in every mode, so a depth change needs no flush
  assign delay_length = {fsk_detect_pkg::path_depth(path_code), 1'b0};

  symbol_delay_line u_delay (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_push(strobe_d),
    .i_symbol(slice_symbol),
    .i_length(delay_length),
    .o_symbol(delayed_symbol)
  );

  // oversampling enable from the symbol divider
  // A divider value of N gives one tick every N+1 clocks
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_cnt <= 16'h0000;
      ovs_en <= 1'b0;
    end else if (div_cnt >= symbol_div) begin
      div_cnt <= 16'h0000;
      ovs_en <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      ovs_en <= 1'b0;
    end
  end

  // recovery threshold scaled to samples
  // Scaled into sample units like the slice level
  assign recov_thr = $signed(16'({recov_level, {fsk_detect_pkg::THR_SHIFT{1'b0}}}));

  // Polarity with hysteresis, flips only past the recovery threshold
  always_comb begin
    next_polarity = polarity;
    if (filt_b > recov_thr) next_polarity = 1'b1;
    else if (filt_b < -recov_thr) next_polarity = 1'b0;
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      polarity <= 1'b0;
    end else if (ovs_en) begin
      polarity <= next_polarity;
    end
  end

  // phase counter, realigned on a transition when correction is on
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      phase <= 5'h00;
    end else if (ovs_en) begin
      if (detect_setup[fsk_detect_pkg::PHASE_CORR_BIT] && (next_polarity != polarity)) begin
        phase <= fsk_detect_pkg::PHASE_REALIGN;
      end else begin
        phase <= phase + 5'h01;
      end
    end
  end

  // One decision per 32 oversampling ticks
  assign symbol_strobe = ovs_en && (phase == fsk_detect_pkg::OVERSAMPLE_LAST);

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      strobe_d <= 1'b0;
    end else begin
      strobe_d <= symbol_strobe;
    end
  end

  // output the delayed or direct decision
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rx_symbol <= 2'h0;
      o_rx_valid <= 1'b0;
    end else begin
      o_rx_valid <= strobe_d && (mode != fsk_detect_pkg::MODE_OFF);
      // Unused select codes update nothing, so the symbol never moves without a pulse
      if (strobe_d && (mode != fsk_detect_pkg::MODE_OFF)) begin
        o_rx_symbol <= trellis_on ? delayed_symbol : slice_symbol;
      end
    end
  end

  // preamble qualifier counts successive symbol changes in 3FSK
  // A repeated symbol clears the count, so noise cannot build up a false find
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      qual_cnt <= 4'h0;
      prev_symbol <= 2'h0;
      o_preamble_found <= 1'b0;
    end else if (mode != fsk_detect_pkg::MODE_3FSK) begin
      qual_cnt <= 4'h0;
      o_preamble_found <= 1'b0;
    end else if (strobe_d) begin
      prev_symbol <= slice_symbol;
      if (slice_symbol == prev_symbol) begin
        qual_cnt <= 4'h0;
        o_preamble_found <= 1'b0;
      end else if (qual_cnt >= qual_time) begin
        o_preamble_found <= 1'b1;
      end else begin
        qual_cnt <= qual_cnt + 4'h1;
      end
    end
  end

endmodule : fsk_demod_detect_config

// file: verif/fsk_demod_detect_config_assertions.sv
// Port-level assertion checker for the FSK detection block
`timescale 1ns/100ps
module fsk_demod_detect_config_assertions (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // Correlator setup and symbols
  input wire logic o_corr_enable,
  input wire logic [9:0] o_corr_bw,
  input wire logic o_corr_odd,
  input wire logic [1:0] o_corr_half,
  input wire logic [1:0] o_rx_symbol,
  input wire logic o_rx_valid
);
  logic [31:0] demod;
  logic [31:0] detect;
  wire logic [2:0] sel = demod[6:4];
  wire logic [9:0] bw = demod[19:10];
  wire logic odd = demod[7];
  wire logic [1:0] half = demod[9:8];
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  // Shadow copies of both setup words
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      demod <= 32'h0000_0000;
      detect <= 32'h03C0_1000;
    end else if (i_wr && i_addr == 4'h0) begin
      demod <= i_wdata;
    end else if (i_wr && i_addr == 4'h4) begin
      detect <= i_wdata;
    end
  end
  // Read request at a given address
  sequence s_rd(logic [3:0] a);
    i_rd && i_addr == a;
  endsequence
  a_corr_enable_map: assert property (
    o_corr_enable == ($past(sel) inside {3'h1, 3'h2, 3'h3})) else $error("corr enable");
  a_corr_bw_copy: assert property (
    o_corr_bw == $past(bw)) else $error("corr bw");
  a_coef_odd_copy: assert property (
    o_corr_odd == $past(odd)) else $error("coef odd");
  a_coef_half_map: assert property (
    o_corr_half == ($past(sel) == 3'h3 ? 2'h0 : $past(half))) else $error("coef half");
  a_unused_silent: assert property (
    sel[2] [*4] |-> !o_rx_valid) else $error("valid in unused mode");
  a_valid_gap: assert property (
    o_rx_valid |=> !o_rx_valid [*8]) else $error("symbol gap short");
  a_symbol_hold: assert property (
    !o_rx_valid |-> $stable(o_rx_symbol)) else $error("symbol moved");
  a_read_demod: assert property (
    s_rd(4'h0) |-> ##1 o_rdata == $past(demod)) else $error("demod read");
  a_read_detect: assert property (
    s_rd(4'h4) |-> ##1 o_rdata == $past(detect)) else $error("detect read");
endmodule : fsk_demod_detect_config_assertions

bind fsk_demod_detect_config fsk_demod_detect_config_assertions u_chk (
  .i_mclk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_corr_enable,
  .o_corr_bw, .o_corr_odd, .o_corr_half, .o_rx_symbol, .o_rx_valid);

// file: verif/fsk_tx_model.sv
// Remote transmitter model feeding discriminator samples
`timescale 1ns/100ps
module fsk_tx_model (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Commanded level and preamble toggle
  input wire logic signed [15:0] i_level,
  input wire logic i_alt,
  // Samples to the receiver
  output logic o_valid,
  output logic signed [15:0] o_corr,
  output logic signed [15:0] o_lin
);
  logic [4:0] cnt;
  logic neg;
  // alternating preamble, one symbol per 32 samples
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt <= 5'h00;
      neg <= 1'b0;
    end else begin
      cnt <= cnt + 5'h01;
      if (cnt == 5'h1F) neg <= i_alt & ~neg;
    end
  end
  // One sample a clock; the linear path sees the same tone
  assign o_valid = ~i_sys_rst;
  assign o_corr = neg ? -i_level : i_level;
  assign o_lin = o_corr;
endmodule : fsk_tx_model

// file: verif/fsk_demod_detect_config_tb.sv
// Self-checking testbench for the FSK detection block
`timescale 1ns/100ps
module fsk_demod_detect_config_tb;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic signed [15:0] lvl = 16'sh0000;
  logic alt = 1'b0;
  logic v;
  logic signed [15:0] cs;
  logic signed [15:0] ls;
  logic [31:0] o_rdata;
  logic o_corr_enable;
  logic [9:0] o_corr_bw;
  logic o_corr_odd;
  logic [1:0] o_corr_half;
  logic [1:0] o_rx_symbol;
  logic o_rx_valid;
  logic o_preamble_found;
  logic [9:0] k;
  logic [1:0] h;
  int err_count = 0;
  int checks = 0;
  int n;
  int n0;
  int lv[9] = '{200, -200, 2000, 200, -2000, 2000, 200, -200, -2000};
  int d[4] = '{4, 6, 8, 32};
  logic [17:0] t_sym = 18'h0_6F11;

  // Clock
  always #2.5 i_mclk = ~i_mclk;

  fsk_demod_detect_config dut (.i_mclk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_sample_valid(v), .i_corr_sample(cs), .i_linear_sample(ls),
    .o_corr_enable, .o_corr_bw, .o_corr_odd, .o_corr_half, .o_rx_symbol, .o_rx_valid,
    .o_preamble_found);
  fsk_tx_model tx (.i_mclk, .i_sys_rst, .i_level(lvl), .i_alt(alt), .o_valid(v),
    .o_corr(cs), .o_lin(ls));

  // Comparison and reporting
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic results();
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  // Register bus cycles
  task automatic wr(input logic [3:0] a, input logic [31:0] dt);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= dt;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string s);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk(s, e, o_rdata);
  endtask : rd

  // Setup words: demodulator select and detector fields
  // software field values
  function automatic logic [31:0] dm(input logic [2:0] s);
    dm = {2'h0, 10'h3FF, 10'h000, 3'h0, s, 4'h0};
  endfunction : dm

  function automatic logic [31:0] det(input logic [3:0] q, input logic [1:0] p,
                                      input logic t);
    det = {6'h00, q, 7'h28, p, 1'b0, t, 7'h20, 4'h0};
  endfunction : det

  // Wait for a number of symbol pulses, bounded
  task automatic wait_sym(input int c);
    int t;
    t = 0;
    repeat (c) begin
      @(posedge i_mclk);
      while (o_rx_valid !== 1'b1 && t < 9000) begin
        @(posedge i_mclk);
        t++;
      end
    end
    if (t >= 9000) chk("symbol wait", 0, 1);
  endtask : wait_sym

  // Symbols from a level step to the first low decision
  task automatic lat(input logic [31:0] w, output int c);
    wr(4'h4, w);
    lvl <= 16'sd2000;
    wait_sym(70);
    lvl <= -16'sd2000;
    c = 0;
    do begin
      wait_sym(1);
      c++;
    end while (o_rx_symbol !== 2'h3 && c < 100);
  endtask : lat

  // Watchdog
  initial begin
    #400000;
    err_count++;
    results();
  end

  // Test sequence
  initial begin
    repeat (4) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    rd(4'h0, 32'h0000_0000, "demod reset");
    rd(4'h4, 32'h03C0_1000, "detect reset");
    wr(4'h8, 32'hABCD_1234);
    wr(4'h6, 32'hFFFF_FFFF);
    rd(4'h8, 32'h0000_1234, "symbol div");
    rd(4'h6, 32'h0000_0000, "unmapped");
    wr(4'h8, 32'h0000_0000);
    // All eight select codes with odd and even K
    for (int i = 4; i < 12; i++) begin
      k = 10'(i);
      n = i + (i & 1);
      h = {1'b0, n[1]};
      wr(4'h0, {2'h0, 10'h3FF, k, h, k[0], 3'(i), 4'h0});
      repeat (2) @(posedge i_mclk);
      #1;
      chk("enable", 32'(i > 8), 32'(o_corr_enable));
      chk("bw", 32'(k), 32'(o_corr_bw));
      chk("odd", 32'(k[0]), 32'(o_corr_odd));
      chk("half", i == 11 ? 0 : 32'(h), 32'(o_corr_half));
    end
    // Threshold decisions in each correlator mode
    wr(4'h4, det(4'hF, 2'h0, 1'b0));
    rd(4'h4, det(4'hF, 2'h0, 1'b0), "detect");
    for (int i = 0; i < 9; i++) begin
      wr(4'h0, dm(3'(i < 2 ? 1 : i < 5 ? 2 : 3)));
      lvl <= 16'(lv[i]);
      wait_sym(4);
      chk("symbol", 32'(t_sym[2*i+:2]), 32'(o_rx_symbol));
    end
    // Unused select code stays silent
    wr(4'h0, dm(3'h5));
    n = 0;
    repeat (3) @(posedge i_mclk);
    repeat (200) begin
      @(posedge i_mclk);
      if (o_rx_valid === 1'b1) n++;
    end
    chk("unused valid", 0, 32'(n));
    // Trellis latency for every path depth
    wr(4'h0, dm(3'h2));
    lat(det(4'hF, 2'h0, 1'b0), n0);
    for (int i = 0; i < 4; i++) begin
      lat(det(4'hF, 2'(i), 1'b1), n);
      chk("trellis delay", 32'(n0 + 2 * d[i]), 32'(n));
    end
    // Preamble qualifier with a short time field
    wr(4'h4, det(4'h4, 2'h0, 1'b0));
    lvl <= 16'sd2000;
    alt <= 1'b1;
    wait_sym(3);
    chk("found early", 0, 32'(o_preamble_found));
    wait_sym(10);
    chk("found", 1, 32'(o_preamble_found));
    alt <= 1'b0;
    wait_sym(4);
    chk("found cleared", 0, 32'(o_preamble_found));
    results();
  end
endmodule : fsk_demod_detect_config_tb
